// File: verilog/mbox_pkg.sv
// constants shared by the audio end, the radio end and the mailbox channel
// assumes one 50 MHz clock (pclk) and an active-low asynchronous reset
package mbox_pkg;

  // ******************************************************************
  // widths and counts
  // ******************************************************************
  localparam int DW         = 24;
  localparam int NUM_IN     = 5;
  localparam int NUM_OUT    = 4;
  localparam int NUM_USER   = 8;
  localparam int NUM_SHARED = 6;
  localparam int CFG_W      = 18;

  // ******************************************************************
  // register offsets (byte addresses, one 32-bit word each; INBUF_OFS and OUTBUF_OFS start blocks of words)
  // ******************************************************************
  localparam logic [7:0] A2R_R1_OFS    = 8'h00;
  localparam logic [7:0] A2R_R2_OFS    = 8'h04;
  localparam logic [7:0] R2A_R1_OFS    = 8'h08;
  localparam logic [7:0] R2A_R2_OFS    = 8'h0C;
  localparam logic [7:0] FLAG_DIR_OFS  = 8'h10;
  localparam logic [7:0] FLAG_STR_OFS  = 8'h14;
  localparam logic [7:0] FLAG_OUT_OFS  = 8'h18;
  localparam logic [7:0] FLAG_IN_OFS   = 8'h1C;
  localparam logic [7:0] AUD_CFG_OFS   = 8'h20;
  localparam logic [7:0] TS_REF_OFS    = 8'h24;
  localparam logic [7:0] TS_SRC_OFS    = 8'h28;
  localparam logic [7:0] INBUF_OFS     = 8'h40;
  localparam logic [7:0] OUTBUF_OFS    = 8'h60;
  localparam logic [7:0] WATCHDOG_UNIT_CTRL_OFS = 8'h90;

  // ******************************************************************
  // reset values and field positions
  // ******************************************************************
  localparam logic [7:0]       FLAG_DIR_RST  = 8'h00;
  localparam logic [7:0]       FLAG_STR_RST  = 8'h00;
  localparam logic [8:0]       FLAG_OUT_RST  = 9'h000;
  localparam logic [7:0]       WATCHDOG_UNIT_CTRL_RST = 8'h00;
  localparam logic [CFG_W-1:0] AUD_CFG_RST   = 18'h00000;
  localparam logic             EMPTY_RST     = 1'b1;
  localparam logic             FULL_RST      = 1'b0;
  localparam int WD_SHARE_BIT = 0;
  localparam int CFG_IN_EN_LO = 9;
  localparam int CFG_OUT_EN_LO = 14;
  localparam logic REG_FIRST  = 1'b0;
  localparam logic REG_SECOND = 1'b1;

endpackage

// File: verilog/mbox_if.sv
// link between the audio core end and the radio core end of the mailbox
// assumes both ends run on the same pclk; strobes are one-cycle pulses
`timescale 1ns/1ps
interface mbox_if;
  import mbox_pkg::*;
  logic                  r2a_wr;
  logic                  r2a_sel;
  logic [DW-1:0]         r2a_wdata;
  logic                  a2r_rd2;
  logic [DW-1:0]         a2r_reg1;
  logic [DW-1:0]         a2r_reg2;
  logic                  a2r_full;
  logic                  r2a_empty;
  logic [NUM_SHARED-1:0] radio_flag_out;
  logic [NUM_SHARED-1:0] radio_flag_dir;

  modport audio_end (
    input  r2a_wr, r2a_sel, r2a_wdata, a2r_rd2, radio_flag_out,
           radio_flag_dir,
    output a2r_reg1, a2r_reg2, a2r_full, r2a_empty
  );
  modport radio_end (
    output r2a_wr, r2a_sel, r2a_wdata, a2r_rd2, radio_flag_out,
           radio_flag_dir,
    input  a2r_reg1, a2r_reg2, a2r_full, r2a_empty
  );
endinterface

// File: verilog/mailbox_channel.sv
// one mailbox direction: two data words plus full and empty flags
// assumes writer and reader strobes are single-cycle pulses on pclk
`timescale 1ns/1ps
module mailbox_channel
  import mbox_pkg::*;
#(
  parameter int W = DW
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         wr_en,
  input  wire logic         wr_sel,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd2,
  output logic      [W-1:0] reg1_q,
  output logic      [W-1:0] reg2_q,
  output logic              full_q,
  output logic              empty_q
);

  if (W < 1 || W > 32) begin : g_bad_width
    $error("mailbox width must be 1 to 32");
  end

  typedef struct packed {
    logic [W-1:0] reg1;
    logic [W-1:0] reg2;
    logic         full;
    logic         empty;
  } chan_t;

  chan_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en && wr_sel == REG_FIRST) begin
      s_d.reg1 = wr_data;
    end
    if (wr_en && wr_sel == REG_SECOND) begin
      s_d.reg2 = wr_data;
    end
    if (rd2) begin
      s_d.full  = 1'b0;
      s_d.empty = 1'b1;
    end
    // a second-word write in the same cycle as the read wins: the new word is unread
    if (wr_en && wr_sel == REG_SECOND) begin
      s_d.full  = 1'b1;
      s_d.empty = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{reg1: '0, reg2: '0, full: FULL_RST, empty: EMPTY_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg1_q  = s_q.reg1;
  assign reg2_q  = s_q.reg2;
  assign full_q  = s_q.full;
  assign empty_q = s_q.empty;

endmodule // mailbox_channel

// File: verilog/radio_end.sv
// radio core end of the mailbox: issues writes and reads as strobes
// assumes the user side gives one-cycle requests synchronous to pclk
`timescale 1ns/1ps
module radio_end
  import mbox_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  mbox_if.radio_end                  mb,
  input  wire logic                  wr_en,
  input  wire logic                  wr_sel,
  input  wire logic [DW-1:0]         wr_data,
  input  wire logic                  rd_en,
  input  wire logic                  rd_sel,
  input  wire logic [NUM_SHARED-1:0] flag_out,
  input  wire logic [NUM_SHARED-1:0] flag_dir,
  output logic      [DW-1:0]         rd_data,
  output logic                       rd_valid,
  output logic                       mbox_full,
  output logic                       mbox_empty
);

  typedef struct packed {
    logic                  wr;
    logic                  sel;
    logic [DW-1:0]         wdata;
    logic                  rd2;
    logic [DW-1:0]         rdata;
    logic                  rvalid;
    logic                  full;
    logic                  empty;
    logic [NUM_SHARED-1:0] fout;
    logic [NUM_SHARED-1:0] fdir;
  } radio_t;

  radio_t s_q, s_d;

  always_comb begin
    s_d        = s_q;
    s_d.wr     = wr_en;
    s_d.sel    = wr_en ? wr_sel : s_q.sel;
    s_d.wdata  = wr_en ? wr_data : s_q.wdata;
    s_d.rd2    = rd_en && rd_sel == REG_SECOND;
    s_d.rvalid = rd_en;
    if (rd_en) begin
      s_d.rdata = (rd_sel == REG_SECOND) ? mb.a2r_reg2 : mb.a2r_reg1;
    end
    s_d.full   = mb.a2r_full;
    s_d.empty  = mb.r2a_empty;
    s_d.fout   = flag_out;
    s_d.fdir   = flag_dir;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{sel: REG_FIRST, full: FULL_RST, empty: EMPTY_RST,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign mb.r2a_wr         = s_q.wr;
  assign mb.r2a_sel        = s_q.sel;
  assign mb.r2a_wdata      = s_q.wdata;
  assign mb.a2r_rd2        = s_q.rd2;
  assign mb.radio_flag_out = s_q.fout;
  assign mb.radio_flag_dir = s_q.fdir;
  assign rd_data           = s_q.rdata;
  assign rd_valid          = s_q.rvalid;
  assign mbox_full         = s_q.full;
  assign mbox_empty        = s_q.empty;

endmodule // radio_end

// File: verilog/audio_end.sv
// audio core end: mailbox, user flags, shared pads, core i/o latches
// assumes APB from software, radio end on mb, pads need synchronising
`timescale 1ns/1ps

module audio_end
  import mbox_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  mbox_if.audio_end                    mb,
  input  wire logic                    sample_div_flag,
  input  wire logic                    source_rate_flag,
  input  wire logic                    watchdog_event_output,
  input  wire logic [1:0]              dedicated_flag_pad_in,
  output logic      [1:0]              dedicated_flag_pad_out,
  output logic      [1:0]              dedicated_flag_pad_oe_n,
  input  wire logic [NUM_SHARED-1:0]   shared_flag_pad_in,
  output logic      [NUM_SHARED-1:0]   shared_flag_pad_out,
  output logic      [NUM_SHARED-1:0]   shared_flag_pad_oe_n,
  input  wire logic                    mcu_cfg_we,
  input  wire logic [CFG_W-1:0]        mcu_cfg_wdata,
  input  wire logic [NUM_IN-1:0]       host_in_valid,
  input  wire logic [NUM_IN*DW-1:0]    host_in_data,
  output logic      [NUM_OUT*DW-1:0]   host_out_data,
  output logic                         sample_valid,
  output logic      [CFG_W-1:0]        audio_cfg,
  output logic                         watchdog_status_flag
);

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic [NUM_USER-1:0]         sync1;
    logic [NUM_USER-1:0]         sync2;
    logic [NUM_USER-1:0]         sync3;
    logic [NUM_USER-1:0]         filt;
    logic [NUM_USER-1:0]         stk;
    logic                        stk_f1;
    logic                        f0_prev;
    logic                        f1_prev;
    logic [NUM_USER-1:0]         dir;
    logic [NUM_USER-1:0]         str;
    logic [8:0]                  fout;
    logic [7:0]                  wdc;
    logic [CFG_W-1:0]            cfg;
    logic [DW-1:0]               ts_cnt;
    logic [DW-1:0]               ts_ref;
    logic [DW-1:0]               ts_src;
    logic [NUM_IN-1:0][DW-1:0]   inbuf;
    logic [NUM_IN-1:0]           arrived;
    logic                        svalid;
    logic [NUM_OUT-1:0][DW-1:0]  outbuf;
    logic [NUM_USER-1:0]         pad_out;
    logic [NUM_USER-1:0]         pad_oe_n;
    logic                        wd_stat;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
  } audio_t;

  audio_t s_q, s_d;

  logic [DW-1:0] a2r_r1, a2r_r2, r2a_r1, r2a_r2;
  logic          a2r_full, a2r_empty, r2a_full, r2a_empty;
  logic          acc_prep, acc_done, wr_done;
  logic          a2r_wr, r2a_rd2;
  logic [12:0]   flag_view;

  // true when addr is a word-aligned address inside a block of n words starting at base
  function automatic logic in_block(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int         n);
    return a >= base && int'(a - base) < 4 * n && a[1:0] == 2'b00;
  endfunction

  function automatic int word_idx(input logic [7:0] a,
                                  input logic [7:0] base);
    return int'(a - base) / 4;
  endfunction

  // two wait-free-ish cycles: prep captures read data, done commits
  assign acc_prep = psel && penable && !s_q.pready;
  assign acc_done = psel && penable && s_q.pready;
  assign wr_done  = acc_done && pwrite;
  assign a2r_wr   = wr_done && (paddr == A2R_R1_OFS || paddr == A2R_R2_OFS);
  assign r2a_rd2  = acc_done && !pwrite && paddr == R2A_R2_OFS;

  // ******************************************************************
  // mailbox channels
  // ******************************************************************
  // one channel per direction
  mailbox_channel #(.W(DW)) u_a2r (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (a2r_wr),
    .wr_sel  (paddr == A2R_R2_OFS),
    .wr_data (pwdata[DW-1:0]),
    .rd2     (mb.a2r_rd2),
    .reg1_q  (a2r_r1),
    .reg2_q  (a2r_r2),
    .full_q  (a2r_full),
    .empty_q (a2r_empty)
  );

  mailbox_channel #(.W(DW)) u_r2a (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (mb.r2a_wr),
    .wr_sel  (mb.r2a_sel),
    .wr_data (mb.r2a_wdata),
    .rd2     (r2a_rd2),
    .reg1_q  (r2a_r1),
    .reg2_q  (r2a_r2),
    .full_q  (r2a_full),
    .empty_q (r2a_empty)
  );

  assign mb.a2r_reg1  = a2r_r1;
  assign mb.a2r_reg2  = a2r_r2;
  assign mb.a2r_full  = a2r_full;
  assign mb.r2a_empty = r2a_empty;

  // ******************************************************************
  // flags as the core sees them
  // ******************************************************************
  always_comb begin
    // F2 reader full, F3 writer empty
    flag_view = {s_q.fout[8],
                 (s_q.str & s_q.stk) | (~s_q.str & s_q.filt),
                 a2r_empty, r2a_full, s_q.stk_f1, sample_div_flag};
  end

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    logic [NUM_USER-1:0] drv, val;
    logic [NUM_IN-1:0]   arr, en;
    logic [31:0]         rd;
    logic                hit;
    logic [NUM_USER-1:0] clr;
    drv = '0;
    val = '0;
    arr = '0;
    en  = '0;
    rd  = '0;
    hit = 1'b1;
    clr = '0;
    s_d = s_q;

    // pads: three stages, a change counts when stages two and three agree
    s_d.sync1 = {shared_flag_pad_in, dedicated_flag_pad_in};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < NUM_USER; i++) begin
      if (s_q.sync2[i] == s_q.sync3[i]) begin
        s_d.filt[i] = s_q.sync2[i];
      end
    end

    unique case (1'b1)
      paddr == A2R_R1_OFS:    rd[DW-1:0] = a2r_r1;
      paddr == A2R_R2_OFS:    rd[DW-1:0] = a2r_r2;
      paddr == R2A_R1_OFS:    rd[DW-1:0] = r2a_r1;
      paddr == R2A_R2_OFS:    rd[DW-1:0] = r2a_r2;
      paddr == FLAG_DIR_OFS:  rd[7:0] = s_q.dir;
      paddr == FLAG_STR_OFS:  rd[7:0] = s_q.str;
      paddr == FLAG_OUT_OFS:  rd[8:0] = s_q.fout;
      paddr == FLAG_IN_OFS:   rd[12:0] = flag_view;
      paddr == AUD_CFG_OFS:   rd[CFG_W-1:0] = s_q.cfg;
      paddr == TS_REF_OFS:    rd[DW-1:0] = s_q.ts_ref;
      paddr == TS_SRC_OFS:    rd[DW-1:0] = s_q.ts_src;
      paddr == WATCHDOG_UNIT_CTRL_OFS: rd[7:0] = s_q.wdc;
      in_block(paddr, INBUF_OFS, NUM_IN):
        rd[DW-1:0] = s_q.inbuf[word_idx(paddr, INBUF_OFS)];
      in_block(paddr, OUTBUF_OFS, NUM_OUT):
        rd[DW-1:0] = s_q.outbuf[word_idx(paddr, OUTBUF_OFS)];
      default:                hit = 1'b0;
    endcase

    s_d.pready = acc_prep;
    if (acc_prep) begin
      s_d.prdata  = pwrite ? 32'h0000_0000 : rd;
      s_d.pslverr = !hit;
    end

    // only flags that were actually reported get cleared, so a flag
    // raised between capture and completion survives the read
    if (acc_done && !pwrite && paddr == FLAG_IN_OFS) begin
      clr = s_q.prdata[11:4];
    end

    s_d.stk    = (s_q.stk & ~clr) | s_q.filt;
    s_d.stk_f1 = (s_q.stk_f1 &
                  !(acc_done && !pwrite && paddr == FLAG_IN_OFS &&
                    s_q.prdata[1])) |
                 (source_rate_flag & !s_q.f1_prev);
    s_d.f0_prev = sample_div_flag;
    s_d.f1_prev = source_rate_flag;

    s_d.ts_cnt = s_q.ts_cnt + 1'b1;
    if (sample_div_flag && !s_q.f0_prev) begin
      s_d.ts_ref = s_q.ts_cnt;
    end
    if (source_rate_flag && !s_q.f1_prev) begin
      s_d.ts_src = s_q.ts_cnt;
    end

    if (mcu_cfg_we) begin
      s_d.cfg = mcu_cfg_wdata;
    end

    if (wr_done) begin
      unique case (1'b1)
        paddr == FLAG_DIR_OFS:  s_d.dir = pwdata[7:0];
        paddr == FLAG_STR_OFS:  s_d.str = pwdata[7:0];
        paddr == FLAG_OUT_OFS:  s_d.fout = pwdata[8:0];
        paddr == AUD_CFG_OFS:   s_d.cfg = pwdata[CFG_W-1:0];
        paddr == WATCHDOG_UNIT_CTRL_OFS: s_d.wdc = pwdata[7:0];
        in_block(paddr, OUTBUF_OFS, NUM_OUT):
          s_d.outbuf[word_idx(paddr, OUTBUF_OFS)] = pwdata[DW-1:0];
        default: ;
      endcase
    end

    en  = s_q.cfg[CFG_IN_EN_LO +: NUM_IN];
    arr = s_q.arrived;
    for (int i = 0; i < NUM_IN; i++) begin
      if (host_in_valid[i]) begin
        s_d.inbuf[i] = host_in_data[i*DW +: DW];
        arr[i]       = 1'b1;
      end
    end
    s_d.svalid  = (en != '0) && ((arr & en) == en);
    s_d.arrived = s_d.svalid ? '0 : (arr & en);

    // pad drives if any core outputs
    for (int i = 0; i < NUM_USER; i++) begin
      drv[i] = s_q.dir[i];
      val[i] = s_q.dir[i] & s_q.fout[i];
      if (i >= 2) begin
        drv[i] = drv[i] | mb.radio_flag_dir[i-2];
        val[i] = val[i] | (mb.radio_flag_dir[i-2] & mb.radio_flag_out[i-2]);
      end
    end
    if (s_q.wdc[WD_SHARE_BIT]) begin
      drv[NUM_USER-1] = 1'b1;
      val[NUM_USER-1] = watchdog_event_output;
    end
    s_d.pad_out  = val;
    s_d.pad_oe_n = ~drv;
    s_d.wd_stat  = s_q.fout[8];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{dir: FLAG_DIR_RST, str: FLAG_STR_RST, fout: FLAG_OUT_RST,
               wdc: WATCHDOG_UNIT_CTRL_RST, cfg: AUD_CFG_RST,
               pad_oe_n: '1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata                  = s_q.prdata;
  assign pready                  = s_q.pready;
  assign pslverr                 = s_q.pslverr;
  assign dedicated_flag_pad_out  = s_q.pad_out[1:0];
  assign dedicated_flag_pad_oe_n = s_q.pad_oe_n[1:0];
  assign shared_flag_pad_out     = s_q.pad_out[NUM_USER-1:2];
  assign shared_flag_pad_oe_n    = s_q.pad_oe_n[NUM_USER-1:2];
  assign host_out_data           = s_q.outbuf;
  assign sample_valid            = s_q.svalid;
  assign audio_cfg               = s_q.cfg;
  assign watchdog_status_flag    = s_q.wd_stat;

endmodule // audio_end

// File: dv/mbox_assertions.sv
// checker on the mailbox link between the audio end and the radio end
// assumes one clock pclk and active-low reset presetn
`timescale 1ns/1ps
module mbox_assertions
  import mbox_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  r2a_wr,
  input wire logic                  r2a_sel,
  input wire logic [DW-1:0]         r2a_wdata,
  input wire logic                  a2r_rd2,
  input wire logic [DW-1:0]         a2r_reg1,
  input wire logic [DW-1:0]         a2r_reg2,
  input wire logic                  a2r_full,
  input wire logic                  r2a_empty,
  input wire logic [NUM_SHARED-1:0] radio_flag_out,
  input wire logic [NUM_SHARED-1:0] radio_flag_dir
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********************************************************
  // handshake flags
  // ********************************************************
  rd_clears_full_a: assert property (
    a2r_rd2 |=> !a2r_full) else $error("full kept after read");
  full_fall_cause_a: assert property (
    $fell(a2r_full) |-> $past(a2r_rd2)) else $error("full fell alone");
  full_holds_a: assert property (
    a2r_full && !a2r_rd2 |=> a2r_full) else $error("full lost unread");
  wr2_clears_empty_a: assert property (
    r2a_wr && r2a_sel |=> !r2a_empty) else $error("empty kept");
  wr1_keeps_empty_a: assert property (
    r2a_wr && !r2a_sel && r2a_empty |=> r2a_empty)
    else $error("first word moved empty");
  empty_fall_late_a: assert property (
    $fell(r2a_empty) |-> $past(r2a_wr && r2a_sel))
    else $error("empty fell without second write");
  cover property (a2r_rd2 && a2r_full);
  cover property ($fell(r2a_empty));
  cover property ($rose(r2a_empty));
endmodule // mbox_assertions

// File: dv/audio_core_flags_and_mailbox_test.sv
// testbench joining audio end and radio end through the mailbox link
// assumes APB with one wait state and the offsets of mbox_pkg
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_fail++; $display("Error at %0t: got %h want %h", $time, a, e); end end
module audio_core_flags_and_mailbox_test
  import mbox_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, err, watchdog_unit = 0, wr_en = 0, wr_sel = 0;
  logic rd_en = 0, rd_sel = 0, rd_valid, mbox_full, mbox_empty;
  logic [DW-1:0] wr_data = 0, rd_data;
  logic [NUM_SHARED-1:0] rfo = 0, rfd = 0, s_out, s_oen, s_in;
  logic [1:0] d_out, d_oen;
  int n_fail = 0, samples_checked = 0;
  logic mcfg_we = 0, svld, wsf;
  logic [CFG_W-1:0] mcfg = 0, acfg;
  logic [NUM_IN-1:0] hiv = 0;
  logic [NUM_IN*DW-1:0] hid = 0;
  logic [NUM_OUT*DW-1:0] hout;
  mbox_if mb ();
  // an undriven shared pad floats to a fixed pattern
  assign s_in = (~s_oen & s_out) | (s_oen & 6'h2A);
  always #10 pclk = ~pclk;
  audio_end i_audio_end (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mb(mb),
    .sample_div_flag(1'b0), .source_rate_flag(1'b0),
    .watchdog_event_output(watchdog_unit), .dedicated_flag_pad_in(~d_oen & d_out),
    .dedicated_flag_pad_out(d_out), .dedicated_flag_pad_oe_n(d_oen),
    .shared_flag_pad_in(s_in), .shared_flag_pad_out(s_out),
    .shared_flag_pad_oe_n(s_oen), .mcu_cfg_we(mcfg_we),
    .mcu_cfg_wdata(mcfg), .host_in_valid(hiv),
    .host_in_data(hid), .host_out_data(hout), .sample_valid(svld),
    .audio_cfg(acfg), .watchdog_status_flag(wsf));
  radio_end i_radio_end (.pclk(pclk), .presetn(presetn), .mb(mb),
    .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .rd_en(rd_en),
    .rd_sel(rd_sel), .flag_out(rfo), .flag_dir(rfd), .rd_data(rd_data),
    .rd_valid(rd_valid), .mbox_full(mbox_full), .mbox_empty(mbox_empty));
  mbox_assertions i_mbox_assertions (.pclk(pclk), .presetn(presetn),
    .r2a_wr(mb.r2a_wr), .r2a_sel(mb.r2a_sel), .r2a_wdata(mb.r2a_wdata),
    .a2r_rd2(mb.a2r_rd2), .a2r_reg1(mb.a2r_reg1), .a2r_reg2(mb.a2r_reg2),
    .a2r_full(mb.a2r_full), .r2a_empty(mb.r2a_empty),
    .radio_flag_out(mb.radio_flag_out),
    .radio_flag_dir(mb.radio_flag_dir));
  // ********************************************************
  // bus tasks
  // ********************************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rdat = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rwr(input logic s, input logic [DW-1:0] d);
    @(posedge pclk);
    wr_en <= 1; wr_sel <= s; wr_data <= d;
    @(posedge pclk);
    wr_en <= 0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic rrd(input logic s, input logic [DW-1:0] e);
    int n = 0;
    @(posedge pclk);
    rd_en <= 1; rd_sel <= s;
    @(posedge pclk);
    rd_en <= 0;
    while (rd_valid !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    `CHK(rd_data, e)
    repeat (4) @(posedge pclk);
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task t_reset;
    apb(0, FLAG_IN_OFS, 0); `CHK(rdat[3:2], 2'b10)
    apb(0, 8'hF0, 0); `CHK(err, 1'b1)
  endtask
  task t_a2r;
    apb(1, A2R_R1_OFS, 32'h00123456);
    apb(1, A2R_R2_OFS, 32'h00ABCDEF);
    apb(0, FLAG_IN_OFS, 0); `CHK(rdat[3], 1'b0)
    `CHK(mbox_full, 1'b1)
    rrd(0, 24'h123456); `CHK(mbox_full, 1'b1)
    rrd(1, 24'hABCDEF); `CHK(mbox_full, 1'b0)
    apb(0, FLAG_IN_OFS, 0); `CHK(rdat[3], 1'b1)
  endtask
  task t_r2a;
    rwr(0, 24'h0F0F0F); rwr(1, 24'hF0F0F0);
    `CHK(mbox_empty, 1'b0)
    apb(0, FLAG_IN_OFS, 0); `CHK(rdat[2], 1'b1)
    apb(0, R2A_R1_OFS, 0); `CHK(rdat, 32'h000F0F0F)
    apb(0, R2A_R2_OFS, 0); `CHK(rdat, 32'h00F0F0F0)
    repeat (4) @(posedge pclk);
    `CHK(mbox_empty, 1'b1)
  endtask
  task t_noblock;
    apb(1, A2R_R2_OFS, 32'h00111111);
    apb(1, A2R_R2_OFS, 32'h00222222);
    rrd(1, 24'h222222);
  endtask
  task t_pads;
    rfd <= 6'h01; rfo <= 6'h01; watchdog_unit <= 1;
    apb(1, FLAG_DIR_OFS, 32'h09); apb(1, FLAG_OUT_OFS, 32'h109);
    apb(1, WATCHDOG_UNIT_CTRL_OFS, 32'h01);
    repeat (3) @(posedge pclk);
    `CHK({d_oen[0], d_out[0]}, 2'b01)
    `CHK(s_oen[4:0], 5'b11100)
    `CHK(s_out[1:0], 2'b11)
    `CHK(s_out[5], 1'b1)
    `CHK(wsf, 1'b1)
    // undriven shared pads read back the float pattern
    apb(0, FLAG_IN_OFS, 0); `CHK(rdat[12:4], 9'h1AD)
  endtask
  task t_host;
    @(posedge pclk);
    mcfg_we <= 1; mcfg <= 18'h00600;
    @(posedge pclk);
    mcfg_we <= 0;
    apb(0, AUD_CFG_OFS, 0); `CHK(rdat, 32'h00000600)
    `CHK(acfg, 18'h00600)
    @(posedge pclk);
    hiv <= 5'h01; hid <= {NUM_IN{24'h5A5A5A}};
    @(posedge pclk);
    hiv <= 5'h02;
    @(posedge pclk);
    hiv <= 5'h00;
    `CHK(svld, 1'b0)
    @(posedge pclk);
    `CHK(svld, 1'b1)
    apb(0, INBUF_OFS + 8'h04, 0); `CHK(rdat, 32'h005A5A5A)
    apb(1, OUTBUF_OFS + 8'h04, 32'h00C3C3C3);
    apb(0, OUTBUF_OFS + 8'h04, 0); `CHK(rdat, 32'h00C3C3C3)
    `CHK(hout[47:24], 24'hC3C3C3)
  endtask
  task complete_run;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset(); t_a2r(); t_r2a(); t_noblock(); t_pads(); t_host();
    complete_run();
  end
endmodule // audio_core_flags_and_mailbox_test
